// *** common/dhab_pkg.sv ***
package dhab_pkg;
	localparam int DHAB_AW = 10;
	localparam int DHAB_DW = 32;
	localparam int DHAB_CODE_W = 10;
	localparam int DHAB_FLAGS_W = 7;
	localparam int DHAB_IDX_W = 2;
	localparam int DHAB_TBL_DEPTH = 4;
	localparam int DHAB_ADDR_W = 48;
	localparam int DHAB_LOW_W = 32;
	localparam int DHAB_HI_W = 16;

	// Window offsets inside one instance's base
	localparam logic [1:0] DHAB_OFF_HIGH = 2'h0;
	localparam logic [1:0] DHAB_OFF_LOW  = 2'h1;
	localparam logic [1:0] DHAB_OFF_CMD  = 2'h2;
	localparam logic [1:0] DHAB_OFF_IDLE = 2'h3;

	// Command codes handled inside the bridge
	localparam logic [9:0] DHAB_CODE_CAUSE  = 10'h3a0;
	localparam logic [9:0] DHAB_CODE_MASK   = 10'h3a4;
	localparam logic [9:0] DHAB_CODE_TBL_W0 = 10'h388;
	localparam logic [9:0] DHAB_CODE_TBL_W1 = 10'h38c;

	// Bit positions, counted from the LSB
	localparam int DHAB_CMD_WE_BIT   = 15;
	localparam int DHAB_IDLE_ALL_BIT = 16;
	localparam int DHAB_TBL_RD_BIT   = 23;
	localparam int DHAB_TBL_IDX_LO   = 16;

	// Access type index in the flag, cause and mask fields
	localparam logic [2:0] DHAB_TY_CFG_WR = 3'h6;
	localparam logic [2:0] DHAB_TY_CFG_RD = 3'h5;
	localparam logic [2:0] DHAB_TY_AF_WR  = 3'h4;
	localparam logic [2:0] DHAB_TY_AF_RD  = 3'h3;

	localparam logic [6:0]  DHAB_FLAGS_IDLE = 7'h7f;
	localparam logic [6:0]  DHAB_MASK_RST   = 7'h00;
	localparam logic [6:0]  DHAB_CAUSE_RST  = 7'h00;
	localparam logic [31:0] DHAB_WORD_RST   = 32'h0000_0000;

	localparam logic [9:0] DHAB_MAC0_BASE_DEF = 10'h000;
	localparam logic [9:0] DHAB_MAC1_BASE_DEF = 10'h004;

	typedef struct packed {
		logic        mac;
		logic [9:0]  addr;
		logic        we;
		logic [31:0] wdata;
	} dhab_host_req_t;

	typedef enum {DHAB_ST_IDLE, DHAB_ST_LOCAL, DHAB_ST_HOST} dhab_state_t;
endpackage

// *** src/dhab_bridge.sv ***
`timescale 1ns/1ps
module dhab_bridge #(
	parameter logic [9:0] MAC0_BUS_BASE = dhab_pkg::DHAB_MAC0_BASE_DEF,
	parameter logic [9:0] MAC1_BUS_BASE = dhab_pkg::DHAB_MAC1_BASE_DEF
) (
	input  wire logic                     I_CLOCK,
	input  wire logic                     I_RST_N,
	input  wire logic [9:0]               I_DCR_ADDR,
	input  wire logic                     I_DCR_READ,
	input  wire logic                     I_DCR_WRITE,
	input  wire logic [31:0]              I_DCR_WR_DBUS,
	output logic                          O_DCR_ACK,
	output logic [31:0]                   O_DCR_RD_DBUS,
	output logic                          O_HOST_REQ,
	output dhab_pkg::dhab_host_req_t      O_HOST_CMD,
	input  wire logic                     I_HOST_DONE,
	input  wire logic [31:0]              I_HOST_RDATA,
	output logic                          O_DONE_IRQ
);
	import dhab_pkg::*;

	function automatic logic [6:0] dhab_flags(input logic busy, input logic [2:0] ty);
		dhab_flags = busy ? (DHAB_FLAGS_IDLE & ~(7'h01 << ty)) : DHAB_FLAGS_IDLE;
	endfunction

	function automatic logic is_local(input logic [9:0] code);
		is_local = (code == DHAB_CODE_CAUSE) || (code == DHAB_CODE_MASK) ||
			(code == DHAB_CODE_TBL_W0) || (code == DHAB_CODE_TBL_W1);
	endfunction

	dhab_state_t      state_r, state_nxt;
	logic [1:0][31:0] hi_r, hi_nxt;
	logic [1:0][31:0] lo_r, lo_nxt;
	logic [1:0][31:0] cmd_r, cmd_nxt;
	logic [1:0][31:0] stage_r, stage_nxt;
	logic [1:0][6:0]  cause_r, cause_nxt;
	logic [1:0][6:0]  mask_r, mask_nxt;
	logic [2:0]       typ_r, typ_nxt;
	logic             evt_r, evt_nxt;
	dhab_host_req_t   req_r, req_nxt;
	logic             ack_r, ack_nxt;
	logic [31:0]      rdata_r, rdata_nxt;
	logic [47:0]      tbl_r [0:1][0:DHAB_TBL_DEPTH-1];

	logic        hit0, hit1, access, sel, done_ev, issue, tbl_we;
	logic [1:0]  off, tbl_idx;
	logic [47:0] tbl_data, tbl_rd;
	logic [6:0]  flags [0:1];
	logic        all_idle;
	logic [9:0]  code;

	assign hit0   = I_DCR_ADDR[9:2] == MAC0_BUS_BASE[9:2];
	assign hit1   = I_DCR_ADDR[9:2] == MAC1_BUS_BASE[9:2];
	assign sel    = hit1;
	assign off    = I_DCR_ADDR[1:0];
	// Strobe is held until ack, so the ack cycle itself must not act twice
	assign access = (I_DCR_READ | I_DCR_WRITE) & (hit0 | hit1) & ~ack_r;
	assign code   = I_DCR_WR_DBUS[DHAB_CODE_W-1:0];
	assign issue  = access & I_DCR_WRITE & (off == DHAB_OFF_CMD) &
		(state_r == DHAB_ST_IDLE);
	assign all_idle = state_r == DHAB_ST_IDLE;
	assign flags[0] = dhab_flags(~all_idle & ~req_r.mac, typ_r);
	assign flags[1] = dhab_flags(~all_idle & req_r.mac, typ_r);
	assign tbl_idx  = lo_r[req_r.mac][DHAB_TBL_IDX_LO +: DHAB_IDX_W];
	assign tbl_rd   = tbl_r[req_r.mac][tbl_idx];

	always_comb begin
		state_nxt = state_r;
		hi_nxt    = hi_r;
		lo_nxt    = lo_r;
		cmd_nxt   = cmd_r;
		stage_nxt = stage_r;
		cause_nxt = cause_r;
		mask_nxt  = mask_r;
		typ_nxt   = typ_r;
		evt_nxt   = evt_r;
		req_nxt   = req_r;
		rdata_nxt = rdata_r;
		ack_nxt   = access;
		done_ev   = 1'b0;
		tbl_we    = 1'b0;
		tbl_data  = {tbl_rd[47:32], stage_r[req_r.mac]};
		if (access && I_DCR_READ) begin
			if (off == DHAB_OFF_HIGH) begin
				rdata_nxt = hi_r[sel];
			end else if (off == DHAB_OFF_LOW) begin
				rdata_nxt = lo_r[sel];
			end else if (off == DHAB_OFF_CMD) begin
				rdata_nxt = cmd_r[sel];
			end else begin
				rdata_nxt = {15'h0000, all_idle, 9'h000, flags[sel]};
			end
		end
		if (access && I_DCR_WRITE) begin
			if (off == DHAB_OFF_HIGH) begin
				hi_nxt[sel] = I_DCR_WR_DBUS;
			end else if (off == DHAB_OFF_LOW) begin
				lo_nxt[sel] = I_DCR_WR_DBUS;
			end else if (off == DHAB_OFF_CMD && issue) begin
				cmd_nxt[sel] = I_DCR_WR_DBUS;
			end
		end
		if (issue) begin
			req_nxt.mac   = sel;
			req_nxt.addr  = code;
			req_nxt.we    = I_DCR_WR_DBUS[DHAB_CMD_WE_BIT];
			req_nxt.wdata = lo_r[sel];
			// Cause and mask accesses raise no event, else clearing would re-arm itself
			evt_nxt = !(code == DHAB_CODE_CAUSE || code == DHAB_CODE_MASK);
			typ_nxt = I_DCR_WR_DBUS[DHAB_CMD_WE_BIT] ? DHAB_TY_CFG_WR : DHAB_TY_CFG_RD;
			if (code == DHAB_CODE_TBL_W0) begin
				typ_nxt = DHAB_TY_AF_WR;
			end else if (code == DHAB_CODE_TBL_W1) begin
				typ_nxt = lo_r[sel][DHAB_TBL_RD_BIT] ? DHAB_TY_AF_RD : DHAB_TY_AF_WR;
			end
			state_nxt = is_local(code) ? DHAB_ST_LOCAL : DHAB_ST_HOST;
		end
		case (state_r)
			DHAB_ST_LOCAL: begin
				done_ev   = 1'b1;
				state_nxt = DHAB_ST_IDLE;
				if (req_r.addr == DHAB_CODE_CAUSE) begin
					if (req_r.we) begin
						cause_nxt[req_r.mac] = lo_r[req_r.mac][6:0];
					end else begin
						lo_nxt[req_r.mac] = {25'h0, cause_r[req_r.mac]};
					end
				end else if (req_r.addr == DHAB_CODE_MASK) begin
					if (req_r.we) begin
						mask_nxt[req_r.mac] = lo_r[req_r.mac][6:0];
					end else begin
						lo_nxt[req_r.mac] = {25'h0, mask_r[req_r.mac]};
					end
				end else if (req_r.addr == DHAB_CODE_TBL_W0) begin
					stage_nxt[req_r.mac] = lo_r[req_r.mac];
				end else if (lo_r[req_r.mac][DHAB_TBL_RD_BIT]) begin
					hi_nxt[req_r.mac] = {16'h0000, tbl_rd[47:32]};
					lo_nxt[req_r.mac] = tbl_rd[31:0];
				end else begin
					tbl_we   = 1'b1;
					tbl_data = {lo_r[req_r.mac][15:0], stage_r[req_r.mac]};
				end
			end
			DHAB_ST_HOST: begin
				if (I_HOST_DONE) begin
					done_ev   = 1'b1;
					state_nxt = DHAB_ST_IDLE;
					if (!req_r.we) begin
						lo_nxt[req_r.mac] = I_HOST_RDATA;
					end
				end
			end
			default: begin
			end
		endcase
		// Set after any cause write so a completing event whose mask bit is set is never lost
		if (done_ev && evt_r && mask_r[req_r.mac][typ_r]) begin
			cause_nxt[req_r.mac][typ_r] = 1'b1;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_r <= DHAB_ST_IDLE;
			hi_r    <= {2{DHAB_WORD_RST}};
			lo_r    <= {2{DHAB_WORD_RST}};
			cmd_r   <= {2{DHAB_WORD_RST}};
			stage_r <= {2{DHAB_WORD_RST}};
			cause_r <= {2{DHAB_CAUSE_RST}};
			mask_r  <= {2{DHAB_MASK_RST}};
			typ_r   <= DHAB_TY_CFG_RD;
			evt_r   <= 1'b0;
			req_r   <= '0;
			ack_r   <= 1'b0;
			rdata_r <= DHAB_WORD_RST;
		end else begin
			state_r <= state_nxt;
			hi_r    <= hi_nxt;
			lo_r    <= lo_nxt;
			cmd_r   <= cmd_nxt;
			stage_r <= stage_nxt;
			cause_r <= cause_nxt;
			mask_r  <= mask_nxt;
			typ_r   <= typ_nxt;
			evt_r   <= evt_nxt;
			req_r   <= req_nxt;
			ack_r   <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Table has no reset; contents are undefined until software writes them
	always_ff @(posedge I_CLOCK) begin
		if (tbl_we) begin
			tbl_r[req_r.mac][tbl_idx] <= tbl_data;
		end
	end

	assign O_DCR_ACK     = ack_r;
	assign O_DCR_RD_DBUS = rdata_r;
	assign O_HOST_REQ    = state_r == DHAB_ST_HOST;
	assign O_HOST_CMD    = req_r;
	assign O_DONE_IRQ    = |{cause_r[0], cause_r[1]};

	ack_single_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		O_DCR_ACK |=> !O_DCR_ACK) else $error("ack lasted more than one cycle");
	// Checks the fall after a zero cause write, not the OR itself, which would hold trivially
	irq_or_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(state_r == DHAB_ST_LOCAL && req_r.addr == DHAB_CODE_CAUSE && req_r.we &&
		lo_r[req_r.mac][6:0] == DHAB_CAUSE_RST && cause_r[!req_r.mac] == DHAB_CAUSE_RST)
		|=> !O_DONE_IRQ) else $error("irq not dropped after cause clear");
	irq_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(O_DONE_IRQ &&
		!(state_r == DHAB_ST_LOCAL && req_r.addr == DHAB_CODE_CAUSE && req_r.we))
		|=> O_DONE_IRQ) else $error("irq dropped without a cause write");
	idle_flag_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(access && I_DCR_READ && off == DHAB_OFF_IDLE && state_r != DHAB_ST_IDLE)
		|=> !O_DCR_RD_DBUS[DHAB_IDLE_ALL_BIT]) else $error("idle bit high while busy");
	cmd_ignore_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(O_HOST_REQ && access && I_DCR_WRITE && off == DHAB_OFF_CMD && !I_HOST_DONE)
		|=> $stable(O_HOST_CMD) && O_HOST_REQ) else $error("command taken while busy");
	host_addr_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(issue && !is_local(code)) |=> O_HOST_REQ &&
		O_HOST_CMD.addr == $past(I_DCR_WR_DBUS[9:0]) && O_HOST_CMD.wdata == $past(lo_r[sel]))
		else $error("host command not passed through");
	read_ret_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(O_HOST_REQ && I_HOST_DONE && !req_r.we) |=>
		lo_r[$past(req_r.mac)] == $past(I_HOST_RDATA) && !O_HOST_REQ)
		else $error("read data not in low word");
	cause_set_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(done_ev && evt_r && mask_r[req_r.mac][typ_r]) |=>
		cause_r[$past(req_r.mac)][$past(typ_r)] && O_DONE_IRQ)
		else $error("enabled completion not recorded");
	mask_gate_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(done_ev && !mask_r[req_r.mac][typ_r] && state_r == DHAB_ST_HOST) |=>
		$stable(cause_r)) else $error("masked completion changed cause");
	local_done_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(state_r == DHAB_ST_LOCAL) |-> (flags[req_r.mac] != DHAB_FLAGS_IDLE)
		##1 (state_r == DHAB_ST_IDLE)) else $error("local access not done in one cycle");
	cause_rd_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(state_r == DHAB_ST_LOCAL && req_r.addr == DHAB_CODE_CAUSE && !req_r.we) |=>
		lo_r[$past(req_r.mac)][6:0] == $past(cause_r[req_r.mac]))
		else $error("cause value not in low word");
	cause_wr_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(state_r == DHAB_ST_LOCAL && req_r.addr == DHAB_CODE_CAUSE && req_r.we) |=>
		cause_r[$past(req_r.mac)] == $past(lo_r[req_r.mac][6:0]))
		else $error("low word not copied into cause");
	mask_rd_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(state_r == DHAB_ST_LOCAL && req_r.addr == DHAB_CODE_MASK && !req_r.we) |=>
		lo_r[$past(req_r.mac)][6:0] == $past(mask_r[req_r.mac]))
		else $error("mask value not in low word");
	mask_wr_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(state_r == DHAB_ST_LOCAL && req_r.addr == DHAB_CODE_MASK && req_r.we) |=>
		mask_r[$past(req_r.mac)] == $past(lo_r[req_r.mac][6:0]))
		else $error("low word not copied into mask");
	stage_load_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(state_r == DHAB_ST_LOCAL && req_r.addr == DHAB_CODE_TBL_W0) |=>
		stage_r[$past(req_r.mac)] == $past(lo_r[req_r.mac]))
		else $error("table word 0 not staged");
	tbl_rd_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(state_r == DHAB_ST_LOCAL && req_r.addr == DHAB_CODE_TBL_W1 &&
		lo_r[req_r.mac][DHAB_TBL_RD_BIT]) |=> hi_r[$past(req_r.mac)][15:0] ==
		$past(tbl_rd[47:32]) && lo_r[$past(req_r.mac)] == $past(tbl_rd[31:0]))
		else $error("table entry not returned");
	tbl_wr_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		tbl_we |=> tbl_r[$past(req_r.mac)][$past(tbl_idx)] ==
		{$past(lo_r[req_r.mac][15:0]), $past(stage_r[req_r.mac])})
		else $error("table entry not committed");
	cfg_busy_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		O_HOST_REQ |-> !flags[O_HOST_CMD.mac][O_HOST_CMD.we ? DHAB_TY_CFG_WR : DHAB_TY_CFG_RD])
		else $error("ready flag high while host access pending");

	host_read_c: cover property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		O_HOST_REQ && I_HOST_DONE && !req_r.we);
	tbl_read_c: cover property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		state_r == DHAB_ST_LOCAL && req_r.addr == DHAB_CODE_TBL_W1 && !tbl_we);
	cause_clear_c: cover property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		O_DONE_IRQ ##[1:200] !O_DONE_IRQ);
	cfg_write_c: cover property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		O_HOST_REQ && I_HOST_DONE && req_r.we);
	tbl_write_c: cover property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		tbl_we);
endmodule // dhab_bridge

// *** tb/dhab_mac_model.sv ***
`timescale 1ns/1ps
module dhab_mac_model (
	input  wire logic                     i_clock,
	input  wire logic                     i_rst_n,
	input  wire logic                     i_req,
	input  wire dhab_pkg::dhab_host_req_t i_cmd,
	input  wire logic [3:0]               i_latency,
	output logic                          o_done,
	output logic [31:0]                   o_rdata
);
	logic [3:0]  wait_r;
	logic [31:0] last_r;
	logic [31:0] answer;
	// Answer carries instance and address, so a misrouted access shows in the data
	assign answer = {16'hc0de, 5'h00, i_cmd.mac, i_cmd.addr};
	assign o_done = i_req && (wait_r == i_latency);
	// Outside a reply the lines show the inverse of the last one, never a stale copy
	assign o_rdata = o_done ? answer : ~last_r;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wait_r <= 4'h0;
			last_r <= 32'h0;
		end else begin
			wait_r <= (i_req && !o_done) ? wait_r + 4'h1 : 4'h0;
			if (o_done)
				last_r <= answer;
		end
	end
endmodule // dhab_mac_model

// *** tb/dhab_bridge_test.sv ***
`timescale 1ns/1ps
module dhab_bridge_test;
	import dhab_pkg::*;
	localparam logic [9:0] b0 = DHAB_MAC0_BASE_DEF;
	localparam logic [9:0] b1 = DHAB_MAC1_BASE_DEF;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, ack, host_req, done, irq, req_q = 0;
	logic [9:0]  addr = 10'h0;
	logic [31:0] wdat = 32'h0, rdat, hrdata, q;
	logic [3:0]  lat = 4'hc;
	dhab_host_req_t host_cmd;
	int n_mismatch = 0, num_checks = 0, cycles = 0, n_req = 0, r0;
	dhab_bridge DUT (.I_CLOCK(clk), .I_RST_N(rst_n), .I_DCR_ADDR(addr), .I_DCR_READ(rd),
		.I_DCR_WRITE(wr), .I_DCR_WR_DBUS(wdat), .O_DCR_ACK(ack), .O_DCR_RD_DBUS(rdat),
		.O_HOST_REQ(host_req), .O_HOST_CMD(host_cmd), .I_HOST_DONE(done),
		.I_HOST_RDATA(hrdata), .O_DONE_IRQ(irq));
	dhab_mac_model mac (.i_clock(clk), .i_rst_n(rst_n), .i_req(host_req), .i_cmd(host_cmd),
		.i_latency(lat), .o_done(done), .o_rdata(hrdata));
	always #20 clk = ~clk;
	// Counts host accesses started, so ignored or local commands can be told apart
	always @(posedge clk) begin
		req_q <= host_req;
		if (host_req && !req_q)
			n_req++;
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Request held from just after an edge until the edge that samples the ack
	task automatic bus(input logic we, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic ok);
		int i;
		@(posedge clk);
		#1;
		addr = a; wr = we; rd = !we; wdat = d; ok = 0;
		for (i = 0; i < 8 && !ok; i++) begin
			@(posedge clk);
			ok = (ack === 1'b1);
		end
		r = rdat;
		#1;
		rd = 0; wr = 0;
	endtask
	task automatic put(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic ok;
		bus(1'b1, a, d, r, ok);
		chk("write ack", 1, ok);
	endtask
	task automatic get(input logic [9:0] a, output logic [31:0] r);
		logic ok;
		bus(1'b0, a, 32'h0, r, ok);
		chk("read ack", 1, ok);
	endtask
	task automatic wait_idle(input logic [9:0] b);
		int i;
		for (i = 0; i < 20; i++) begin
			get(b + 10'h3, q);
			if (q[16] === 1'b1) break;
		end
	endtask
	task automatic t_reset();
		logic ok;
		get(b0 + 10'h3, q);
		chk("idle word", 32'h0001007f, q);
		chk("irq", 0, irq);
		put(b0 + 10'h1, 32'h000000ff);
		put(b0 + 10'h2, 32'h000003a4);
		get(b0 + 10'h1, q);
		chk("mask", 0, q);
		bus(1'b0, 10'h010, 32'h0, q, ok);
		chk("unmapped ack", 0, ok);
		$display("reset test done");
	endtask
	task automatic t_mask();
		put(b0 + 10'h1, 32'h0000007f);
		put(b0 + 10'h2, 32'h000083a4);
		put(b0 + 10'h1, 32'h0);
		put(b0 + 10'h2, 32'h000003a4);
		get(b0 + 10'h1, q);
		chk("mask readback", 32'h7f, q);
		$display("mask test done");
	endtask
	task automatic t_cfg_read();
		lat = 4'hc;
		r0 = n_req;
		put(b0 + 10'h2, 32'h00000280);
		chk("host addr", 10'h280, host_cmd.addr);
		chk("host dir", {1'b0, 1'b0}, {host_cmd.mac, host_cmd.we});
		get(b0 + 10'h3, q);
		chk("idle busy", 32'h0000005f, q);
		get(b1 + 10'h3, q);
		chk("idle other", 32'h0000007f, q);
		wait_idle(b0);
		get(b0 + 10'h1, q);
		chk("cfg read data", 32'hc0de0280, q);
		chk("irq set", 1, irq);
		put(b0 + 10'h2, 32'h000003a0);
		get(b0 + 10'h1, q);
		chk("cause", 32'h20, q);
		chk("accesses", r0 + 1, n_req);
		$display("config read test done");
	endtask
	task automatic t_clear();
		put(b0 + 10'h1, 32'h0);
		put(b0 + 10'h2, 32'h000083a0);
		put(b0 + 10'h1, 32'h0000005a);
		put(b0 + 10'h2, 32'h000003a0);
		get(b0 + 10'h1, q);
		chk("cause clear", 0, q);
		chk("irq clear", 0, irq);
		$display("clear test done");
	endtask
	task automatic t_cfg_write();
		lat = 4'h8;
		r0 = n_req;
		put(b1 + 10'h1, 32'h60000000);
		put(b1 + 10'h2, 32'h000082c0);
		chk("host write", {1'b1, 10'h2c0, 1'b1, 32'h60000000}, host_cmd);
		get(b1 + 10'h3, q);
		chk("write pending", 32'h0000003f, q);
		put(b1 + 10'h2, 32'h00000200);
		wait_idle(b1);
		get(b1 + 10'h2, q);
		chk("cmd kept", 32'h000082c0, q);
		get(b1 + 10'h3, q);
		chk("write done", 32'h0001007f, q);
		chk("accesses", r0 + 1, n_req);
		chk("irq masked", 0, irq);
		put(b1 + 10'h2, 32'h000003a0);
		get(b1 + 10'h1, q);
		chk("cause masked", 0, q);
		$display("config write test done");
	endtask
	task automatic t_table();
		r0 = n_req;
		put(b1 + 10'h1, 32'hdeafcafe);
		put(b1 + 10'h2, 32'h00008388);
		wait_idle(b1);
		put(b1 + 10'h1, 32'h0001face);
		put(b1 + 10'h2, 32'h0000838c);
		wait_idle(b1);
		put(b1 + 10'h1, 32'h00810000);
		put(b1 + 10'h2, 32'h0000838c);
		wait_idle(b1);
		get(b1 + 10'h0, q);
		chk("table high", 32'h0000face, q);
		get(b1 + 10'h1, q);
		chk("table low", 32'hdeafcafe, q);
		chk("accesses", r0, n_req);
		$display("table test done");
	endtask
	// Reset lands while a host read is pending, after an earlier one raised the irq
	task automatic t_mid_reset();
		put(b0 + 10'h2, 32'h00000280);
		wait_idle(b0);
		chk("irq before reset", 1, irq);
		put(b0 + 10'h2, 32'h00000280);
		@(posedge clk);
		#1;
		rst_n = 0;
		@(posedge clk);
		#1;
		rst_n = 1;
		chk("req after reset", 0, host_req);
		chk("irq after reset", 0, irq);
		get(b0 + 10'h3, q);
		chk("idle after reset", 32'h0001007f, q);
		put(b0 + 10'h1, 32'h000000ff);
		put(b0 + 10'h2, 32'h000003a4);
		get(b0 + 10'h1, q);
		chk("mask after reset", 0, q);
		$display("mid-run reset test done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1;
		rst_n = 1;
		t_reset();
		t_mask();
		t_cfg_read();
		t_clear();
		t_cfg_write();
		t_table();
		t_mid_reset();
		tally_and_finish();
	end
endmodule // dhab_bridge_test
